// [logic/dcf_params.svh]
/*
 * Constants for the 18-bit programmable-flag buffer and its controller:
 * widths, default offsets, timing counts and the controller's register map.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

// Functional notes
// - controller resets after power-up; buffer comes up empty
// - reset needs falling edge; no accesses meanwhile
// - after reset outputs low when output enabled
// - write enable low stores word each edge
// - read and output enable low present next word
// - output enable high three-states data outputs; here data_out stays driven and only data_out_oe drops
// - full flag low blocks writes, write-clock updated
// - empty flag low blocks reads, read-clock updated
// - empty buffer keeps last read word on outputs
// - two 12-bit thresholds loaded from low data bits
// - load plus write alternates empty, full thresholds
// - partial threshold loads resume at next register
// - load plus read returns thresholds, same alternation
// - unprogrammed thresholds default by depth
// - almost flags compare count against thresholds
// - half-full low above half the depth
// - select pin picks clocked or immediate almost flags
// - retransmit pulse rewinds read pointer to zero
// - controller idles enables during retransmit and recovery
// - after retransmit reread old data, then new
// - flags follow pointers; clocked ones need edge
// - wide stacks AND their empty and full flags

// data path
`define DCF_WORD_W 18
`define DCF_THR_W 12
`define DCF_CMP_W 14
`define DCF_DEPTH 1024

// default threshold offsets by depth
`define DCF_OFS_64 12'h007
`define DCF_OFS_256 12'h01f
`define DCF_OFS_512 12'h03f
`define DCF_OFS_BIG 12'h07f

// timing
`define DCF_CLK_NS 20
`define DCF_RTR_NS 40
`define DCF_RTR_CYC ((`DCF_RTR_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)

// controller register map
`define DCF_ADDR_CTRL 32'h0000_0000
`define DCF_ADDR_CMD 32'h0000_0004
`define DCF_ADDR_WDATA 32'h0000_0008
`define DCF_ADDR_RDATA 32'h0000_000c
`define DCF_ADDR_STATUS 32'h0000_0010

// field positions
`define DCF_CTRL_OE 0
`define DCF_CTRL_SYNC 1
`define DCF_CTRL_LOAD 2
`define DCF_CMD_RESET 0
`define DCF_CMD_READ 1
`define DCF_CMD_RETX 2
`define DCF_ST_BUSY 5

// bus answers
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2

`endif

// [logic/dcf_pkg.sv]
/*
 * Shared types of the buffer and its controller.
 * Assumes the constants header is on the include path.
 */
`include "dcf_params.svh"

package dcf_pkg;

    typedef logic [`DCF_WORD_W-1:0] dcf_word_t;
    typedef logic [`DCF_THR_W-1:0] dcf_thr_t;
    typedef logic [`DCF_CMP_W-1:0] dcf_cnt_t;

    // controller sequencer
    typedef enum logic [2:0] {
        DCF_IDLE = 3'h0,
        DCF_RST = 3'h1,
        DCF_WR = 3'h2,
        DCF_RD = 3'h3,
        DCF_CAP = 3'h4,
        DCF_RTX = 3'h5,
        DCF_RCV = 3'h6
    } dcf_host_state_t;

endpackage

// [logic/dcf_if.sv]
/*
 * Pin bundle between the buffer and the controller that drives it.
 * Assumes both ends share one clock; data_out is driven at all times
 * and data_out_oe only reports the driver enable.
 */
`timescale 1ns/1ps

interface dcf_if;
    logic reset_n;
    logic write_en_n;
    logic read_en_n;
    logic output_en_n;
    logic threshold_load_n;
    logic retransmit;
    logic flag_sync_select_n;
    dcf_pkg::dcf_word_t data_in;
    dcf_pkg::dcf_word_t data_out;
    logic data_out_oe;
    logic empty_flag_n;
    logic full_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic half_full_flag_n;

    modport device (
        input reset_n, write_en_n, read_en_n, output_en_n,
        input threshold_load_n, retransmit, flag_sync_select_n, data_in,
        output data_out, data_out_oe, empty_flag_n, full_flag_n,
        output almost_empty_flag_n, almost_full_flag_n, half_full_flag_n
    );

    modport host (
        output reset_n, write_en_n, read_en_n, output_en_n,
        output threshold_load_n, retransmit, flag_sync_select_n, data_in,
        input data_out, data_out_oe, empty_flag_n, full_flag_n,
        input almost_empty_flag_n, almost_full_flag_n, half_full_flag_n
    );
endinterface

// [logic/dcf_level_flag.sv]
/*
 * One programmable level flag: almost empty or almost full.
 * Assumes counts are zero-extended to the compare width by the caller.
 */
`timescale 1ns/1ps
`include "dcf_params.svh"

module dcf_level_flag #(
    parameter int DEPTH = `DCF_DEPTH,
    parameter bit NEAR_EMPTY = 1'b1
) (
    input wire logic aclk,
    input wire logic rst,
    input wire dcf_pkg::dcf_cnt_t cnt_now,
    input wire dcf_pkg::dcf_cnt_t cnt_next,
    input wire dcf_pkg::dcf_thr_t thr,
    input wire logic sync_sel_n,
    output logic flag_n_q
);
    localparam dcf_pkg::dcf_cnt_t FULL = `DCF_CMP_W'(DEPTH);

    dcf_pkg::dcf_cnt_t cnt;
    dcf_pkg::dcf_cnt_t thr_x;
    logic hit;

    // clocked mode looks at the settled count, so it lags one edge
    always_comb begin
        cnt = sync_sel_n ? cnt_next : cnt_now;
        thr_x = {{(`DCF_CMP_W-`DCF_THR_W){1'b0}}, thr};
        if (NEAR_EMPTY) begin
            hit = (cnt <= thr_x);
        end else begin
            hit = ((cnt + thr_x) >= FULL);
        end
    end

    // reset value matches an empty buffer
    always_ff @(posedge aclk) begin
        if (rst) begin
            flag_n_q <= NEAR_EMPTY ? 1'b0 : 1'b1;
        end else begin
            flag_n_q <= !hit;
        end
    end
endmodule

// [logic/dcf_device.sv]
/*
 * The buffer end: 18-bit store with empty, full, half-full and two
 * programmable level flags, threshold load/readback and retransmit.
 * Assumes write and read ports share aclk and that the controller keeps
 * its enables idle during reset and retransmit recovery.
 */
`timescale 1ns/1ps
`include "dcf_params.svh"

module dcf_device #(
    parameter int DEPTH = `DCF_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    dcf_if.device pins
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
    // unprogrammed offsets depend on depth
    localparam dcf_pkg::dcf_thr_t DEF_OFS =
        (DEPTH == 64) ? `DCF_OFS_64 :
        (DEPTH == 256) ? `DCF_OFS_256 :
        (DEPTH == 512) ? `DCF_OFS_512 : `DCF_OFS_BIG;

    // storage and pointers
    dcf_pkg::dcf_word_t mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] rt_cnt;

    // thresholds and their sequence selectors
    dcf_pkg::dcf_thr_t ae_thr_q;
    dcf_pkg::dcf_thr_t af_thr_q;
    logic sel_w_q;
    logic sel_r_q;

    // output side
    dcf_pkg::dcf_word_t data_out_q;
    logic oe_q;
    logic ef_q;
    logic ff_q;
    logic hf_q;
    logic ae_q;
    logic af_q;

    // decoded strobes
    logic rst;
    logic wr_ok;
    logic rd_ok;
    logic prog_wr;
    logic prog_rd;
    dcf_pkg::dcf_cnt_t cnt_now_x;
    dcf_pkg::dcf_cnt_t cnt_next_x;

    // pin reset folds into the bus reset, both sampled on the clock
    assign rst = !aresetn || !pins.reset_n;

    // decode the four load/enable combinations
    always_comb begin
        prog_wr = !pins.threshold_load_n && !pins.write_en_n;
        prog_rd = !pins.threshold_load_n && !pins.read_en_n;
        // full flag low swallows the write whatever the enable says
        wr_ok = pins.threshold_load_n && !pins.write_en_n && ff_q
            && !pins.retransmit;
        // empty flag low swallows the read, so outputs stay put
        rd_ok = pins.threshold_load_n && !pins.read_en_n
            && !pins.output_en_n && ef_q && !pins.retransmit;
    end

    // count after retransmit is the distance back to location zero;
    // a buffer written exactly full wraps wptr to zero, kept as full
    always_comb begin
        if (wptr_q == '0 && count_q == FULL_CNT) begin
            rt_cnt = FULL_CNT;
        end else begin
            rt_cnt = {1'b0, wptr_q};
        end
    end

    // next word count
    always_comb begin
        count_d = count_q;
        if (pins.retransmit) begin
            count_d = rt_cnt;
        end else if (wr_ok && !rd_ok) begin
            count_d = count_q + 1'b1;
        end else if (rd_ok && !wr_ok) begin
            count_d = count_q - 1'b1;
        end
    end

    // word count register
    always_ff @(posedge aclk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // storage array; no reset, contents are don't-care when empty
    always_ff @(posedge aclk) begin
        if (wr_ok) begin
            mem_q[wptr_q] <= pins.data_in;
        end
    end

    // write pointer, wraps naturally as depths are powers of two
    always_ff @(posedge aclk) begin
        if (rst) begin
            wptr_q <= '0;
        end else if (wr_ok) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    // read pointer; retransmit rewinds to the first location
    always_ff @(posedge aclk) begin
        if (rst) begin
            rptr_q <= '0;
        end else if (pins.retransmit) begin
            rptr_q <= '0;
        end else if (rd_ok) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end

    // output register: buffer words, or thresholds when loading
    always_ff @(posedge aclk) begin
        if (rst) begin
            data_out_q <= '0;
        end else if (rd_ok) begin
            data_out_q <= mem_q[rptr_q];
        end else if (prog_rd) begin
            data_out_q <= {6'h00, sel_r_q ? af_thr_q : ae_thr_q};
        end
    end

    // pin driver enable follows the enable input one edge later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= !pins.output_en_n;
        end
    end

    // threshold registers, loaded from the low data bits
    always_ff @(posedge aclk) begin
        if (rst) begin
            ae_thr_q <= DEF_OFS;
            af_thr_q <= DEF_OFS;
        end else if (prog_wr) begin
            if (sel_w_q) begin
                af_thr_q <= pins.data_in[`DCF_THR_W-1:0];
            end else begin
                ae_thr_q <= pins.data_in[`DCF_THR_W-1:0];
            end
        end
    end

    // sequence selectors survive load going high, so a later
    // access resumes with the other register
    always_ff @(posedge aclk) begin
        if (rst) begin
            sel_w_q <= 1'b0;
        end else if (prog_wr) begin
            sel_w_q <= !sel_w_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            sel_r_q <= 1'b0;
        end else if (prog_rd) begin
            sel_r_q <= !sel_r_q;
        end
    end

    // boundary flags settle on the same edge as the count
    always_ff @(posedge aclk) begin
        if (rst) begin
            ef_q <= 1'b0;
            ff_q <= 1'b1;
            hf_q <= 1'b1;
        end else begin
            ef_q <= (count_d != '0);
            ff_q <= (count_d != FULL_CNT);
            hf_q <= !(count_d > HALF_CNT);
        end
    end

    // level flags work on a common 14-bit count
    assign cnt_now_x = {{(`DCF_CMP_W-CW){1'b0}}, count_q};
    assign cnt_next_x = {{(`DCF_CMP_W-CW){1'b0}}, count_d};

    dcf_level_flag #(
        .DEPTH(DEPTH),
        .NEAR_EMPTY(1'b1)
    ) u_almost_empty (
        .aclk(aclk),
        .rst(rst),
        .cnt_now(cnt_now_x),
        .cnt_next(cnt_next_x),
        .thr(ae_thr_q),
        .sync_sel_n(pins.flag_sync_select_n),
        .flag_n_q(ae_q)
    );

    dcf_level_flag #(
        .DEPTH(DEPTH),
        .NEAR_EMPTY(1'b0)
    ) u_almost_full (
        .aclk(aclk),
        .rst(rst),
        .cnt_now(cnt_now_x),
        .cnt_next(cnt_next_x),
        .thr(af_thr_q),
        .sync_sel_n(pins.flag_sync_select_n),
        .flag_n_q(af_q)
    );

    // every pin comes straight from a register
    assign pins.data_out = data_out_q;
    assign pins.data_out_oe = oe_q;
    assign pins.empty_flag_n = ef_q;
    assign pins.full_flag_n = ff_q;
    assign pins.half_full_flag_n = hf_q;
    assign pins.almost_empty_flag_n = ae_q;
    assign pins.almost_full_flag_n = af_q;
endmodule

// [logic/dcf_host.sv]
/*
 * Controller end: AXI4-Lite registers in, buffer pins out. One command
 * runs at a time; a busy bit in status shows it.
 * Assumes a single buffer lane on the pins and one clock.
 */
`timescale 1ns/1ps
`include "dcf_params.svh"

module dcf_host (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    dcf_if.host pins
);
    dcf_pkg::dcf_host_state_t state_q;
    logic aw_have_q, w_have_q, do_wr, wr_hit, wstrb_any_q;
    logic [31:0] awaddr_q, wdata_q, rmux;
    logic [1:0] rresp_d;
    logic oe_n_q, sync_n_q, load_n_q;
    logic reset_n_q, wen_n_q, ren_n_q, rt_q;
    dcf_pkg::dcf_word_t din_q, rdata_word_q;
    logic [7:0] rcv_q;

    assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
    // strobes are kept from the data beat; the live bus may have moved on
    assign wr_hit = do_wr && wstrb_any_q;

    // write address and data taken in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_any_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DCF_RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && !s_axi_awready
                && !aw_have_q && !s_axi_bvalid;
            s_axi_wready <= s_axi_wvalid && !s_axi_wready
                && !w_have_q && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_any_q <= (s_axi_wstrb != 4'h0);
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == `DCF_ADDR_CTRL
                    || awaddr_q == `DCF_ADDR_CMD
                    || awaddr_q == `DCF_ADDR_WDATA)
                    ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read decode; composite empty/full across lanes would be ANDs,
    // one lane here so the pins are taken as they stand
    always_comb begin
        rmux = 32'h0000_0000;
        rresp_d = `DCF_RESP_OKAY;
        case (s_axi_araddr)
            `DCF_ADDR_CTRL: rmux = {29'h0, !load_n_q, !sync_n_q, !oe_n_q};
            `DCF_ADDR_RDATA: rmux = {14'h0, rdata_word_q};
            `DCF_ADDR_STATUS: rmux = {26'h0, state_q != dcf_pkg::DCF_IDLE,
                pins.full_flag_n, pins.almost_full_flag_n,
                pins.half_full_flag_n, pins.almost_empty_flag_n,
                pins.empty_flag_n};
            default: rresp_d = `DCF_RESP_SLVERR;
        endcase
    end

    // read channel answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DCF_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rmux;
                s_axi_rresp <= rresp_d;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // static pin levels held active low so pins come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_n_q <= 1'b1;
            sync_n_q <= 1'b1;
            load_n_q <= 1'b1;
        end else if (wr_hit && awaddr_q == `DCF_ADDR_CTRL) begin
            oe_n_q <= !wdata_q[`DCF_CTRL_OE];
            sync_n_q <= !wdata_q[`DCF_CTRL_SYNC];
            load_n_q <= !wdata_q[`DCF_CTRL_LOAD];
        end
    end

    // sequencer; commands arriving while busy are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= dcf_pkg::DCF_RST;
            reset_n_q <= 1'b0;
            wen_n_q <= 1'b1;
            ren_n_q <= 1'b1;
            rt_q <= 1'b0;
            din_q <= '0;
            rdata_word_q <= '0;
            rcv_q <= 8'h00;
        end else begin
            unique case (state_q)
                dcf_pkg::DCF_IDLE: begin
                    if (wr_hit && awaddr_q == `DCF_ADDR_WDATA) begin
                        din_q <= wdata_q[`DCF_WORD_W-1:0];
                        wen_n_q <= 1'b0;
                        state_q <= dcf_pkg::DCF_WR;
                    end else if (wr_hit && awaddr_q == `DCF_ADDR_CMD) begin
                        if (wdata_q[`DCF_CMD_RESET]) begin
                            reset_n_q <= 1'b0;
                            state_q <= dcf_pkg::DCF_RST;
                        end else if (wdata_q[`DCF_CMD_RETX]) begin
                            rt_q <= 1'b1;
                            state_q <= dcf_pkg::DCF_RTX;
                        end else if (wdata_q[`DCF_CMD_READ]) begin
                            ren_n_q <= 1'b0;
                            state_q <= dcf_pkg::DCF_RD;
                        end
                    end
                end
                dcf_pkg::DCF_RST: begin
                    reset_n_q <= 1'b1;
                    state_q <= dcf_pkg::DCF_IDLE;
                end
                dcf_pkg::DCF_WR: begin
                    wen_n_q <= 1'b1;
                    state_q <= dcf_pkg::DCF_IDLE;
                end
                dcf_pkg::DCF_RD: begin
                    ren_n_q <= 1'b1;
                    state_q <= dcf_pkg::DCF_CAP;
                end
                dcf_pkg::DCF_CAP: begin
                    rdata_word_q <= pins.data_out;
                    state_q <= dcf_pkg::DCF_IDLE;
                end
                dcf_pkg::DCF_RTX: begin
                    rt_q <= 1'b0;
                    rcv_q <= 8'(`DCF_RTR_CYC);
                    state_q <= dcf_pkg::DCF_RCV;
                end
                dcf_pkg::DCF_RCV: begin
                    // enables stay idle through recovery
                    rcv_q <= rcv_q - 8'h01;
                    if (rcv_q <= 8'h01) begin
                        state_q <= dcf_pkg::DCF_IDLE;
                    end
                end
                default: state_q <= dcf_pkg::DCF_IDLE;
            endcase
        end
    end

    assign pins.reset_n = reset_n_q;
    assign pins.write_en_n = wen_n_q;
    assign pins.read_en_n = ren_n_q;
    assign pins.retransmit = rt_q;
    assign pins.data_in = din_q;
    assign pins.output_en_n = oe_n_q;
    assign pins.flag_sync_select_n = sync_n_q;
    assign pins.threshold_load_n = load_n_q;
endmodule

// [sim/dcf_asserts.sv]
/* pin-bundle checker between host and buffer ends.
   assumes one clock and a synchronous active-low aresetn. */
`timescale 1ns/1ps

module dcf_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reset_n,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic output_en_n,
    input wire logic threshold_load_n,
    input wire logic retransmit,
    input wire dcf_pkg::dcf_word_t data_out,
    input wire logic data_out_oe,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic half_full_flag_n,
    input wire logic almost_empty_flag_n
);
    // one domain, so clock and disable are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // enables held idle while the buffer restarts or rewinds
    sequence quiet;
        write_en_n && read_en_n;
    endsequence

    a_reset_empty:
        assert property (!reset_n |=> !empty_flag_n && full_flag_n &&
            half_full_flag_n && !almost_empty_flag_n)
        else $error("flags not empty after reset");
    a_reset_data:
        assert property (!reset_n |=> data_out == 18'h0)
        else $error("data not cleared by reset");
    a_reset_quiet:
        assert property (!reset_n |-> quiet)
        else $error("access during reset");
    a_oe_late:
        assert property (1'b1 |=> data_out_oe == !$past(output_en_n))
        else $error("output enable not followed");
    a_full_holds:
        assert property (!full_flag_n && !write_en_n && read_en_n &&
            reset_n |=> !full_flag_n)
        else $error("write accepted while full");
    a_empty_holds:
        assert property (!empty_flag_n && !read_en_n && write_en_n &&
            threshold_load_n && reset_n |=>
            !empty_flag_n && $stable(data_out))
        else $error("read accepted while empty");
    a_write_fills:
        assert property (!empty_flag_n && !write_en_n && read_en_n &&
            threshold_load_n && reset_n && !retransmit |=> empty_flag_n)
        else $error("write did not clear empty");
    a_retx_quiet:
        assert property (retransmit |-> quiet ##1 quiet [*2])
        else $error("access during retransmit recovery");
    a_full_half:
        assert property (!full_flag_n |-> !half_full_flag_n &&
            almost_empty_flag_n)
        else $error("full without half and level flags");
endmodule

// [sim/testbench.sv]
/* self-checking bench: host and buffer joined by the pin bundle,
   driven over AXI-Lite. assumes the host register map, one clock. */
`timescale 1ns/1ps
`include "dcf_params.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module testbench;
    localparam int DEPTH = 64;
    localparam int OFS = `DCF_OFS_64;
    localparam logic [31:0] CT = `DCF_ADDR_CTRL;
    localparam logic [31:0] CM = `DCF_ADDR_CMD;
    localparam logic [31:0] WD = `DCF_ADDR_WDATA;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, x;
    logic [4:0] s;
    int mismatches = 0, n_tests = 0;

    dcf_if pins ();
    // 50 MHz
    always #10 aclk = ~aclk;

    // ready lines tied high: every answer is taken at once
    dcf_device #(.DEPTH(DEPTH)) u_dcf_device (
        .aclk(aclk), .aresetn(aresetn), .pins(pins.device));
    dcf_host u_dcf_host (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .pins(pins.host));
    dcf_asserts u_dcf_asserts (
        .aclk(aclk), .aresetn(aresetn), .reset_n(pins.reset_n),
        .write_en_n(pins.write_en_n), .read_en_n(pins.read_en_n),
        .output_en_n(pins.output_en_n), .retransmit(pins.retransmit),
        .threshold_load_n(pins.threshold_load_n),
        .data_out(pins.data_out), .data_out_oe(pins.data_out_oe),
        .empty_flag_n(pins.empty_flag_n), .full_flag_n(pins.full_flag_n),
        .half_full_flag_n(pins.half_full_flag_n),
        .almost_empty_flag_n(pins.almost_empty_flag_n));

    // expected status bits for a word count and two offsets
    function automatic logic [4:0] ex(input int n, input int e, input int f);
        return {n != DEPTH, n < DEPTH - f, n <= DEPTH / 2, n > e, n != 0};
    endfunction

    // bus write: address and data offered together, dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask

    task automatic rd(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        x = rdata;
        resp = rresp;
    endtask

    // commands sent while busy are dropped, so wait for busy low
    task automatic op(input logic [31:0] a, input logic [31:0] d);
        wr(a, d);
        do rd(`DCF_ADDR_STATUS); while (x[`DCF_ST_BUSY] !== 1'b0);
    endtask

    task automatic pop(input logic [31:0] e);
        op(CM, 32'h2);
        s = x[4:0];
        rd(`DCF_ADDR_RDATA);
        `CHK("pop", e, x)
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // the whole run is under two thousand cycles
    initial begin
        #1000000;
        mismatches++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        op(CT, 32'h0);
        `CHK("status", ex(0, OFS, OFS), x[4:0])
        `CHK("oe", 1'b0, pins.data_out_oe)
        wr(32'h40, 32'h1);
        `CHK("bresp", `DCF_RESP_SLVERR, resp)
        rd(32'h40);
        `CHK("rresp", `DCF_RESP_SLVERR, resp)
        op(CT, 32'h1);
        rd(CT);
        `CHK("ctrl", 32'h1, x)
        `CHK("oe", 1'b1, pins.data_out_oe)
        $display("test setup done");
        for (int i = 1; i <= DEPTH + 1; i++) begin
            op(WD, 32'h100 + i);
            `CHK("fill", ex(i - (i > DEPTH), OFS, OFS), x[4:0])
        end
        for (int i = 1; i <= DEPTH + 1; i++) begin
            pop(32'h100 + (i > DEPTH ? DEPTH : i));
            `CHK("drain", ex(i > DEPTH ? 0 : DEPTH - i, OFS, OFS), s)
        end
        $display("test fill and drain done");
        op(CM, 32'h1);
        `CHK("status", ex(0, OFS, OFS), x[4:0])
        for (int i = 1; i <= 3; i++) op(WD, 32'h200 + i);
        pop(32'h201);
        pop(32'h202);
        op(CM, 32'h4);
        `CHK("retx", ex(3, OFS, OFS), x[4:0])
        op(WD, 32'h204);
        for (int i = 1; i <= 4; i++) pop(32'h200 + i);
        `CHK("retx", ex(0, OFS, OFS), s)
        $display("test retransmit done");
        op(CM, 32'h1);
        op(CT, 32'h5);
        op(WD, 32'h5);
        op(CT, 32'h1);
        op(CT, 32'h5);
        op(WD, 32'h3f00a);
        op(WD, 32'h3);
        pop(32'h3);
        pop(32'ha);
        op(CT, 32'h3);
        for (int i = 1; i <= DEPTH - 10; i++) begin
            op(WD, 32'h300 + i);
            `CHK("prog", ex(i, 3, 10), x[4:0])
        end
        $display("test thresholds done");
        test_done();
    end
endmodule
